/* core/dq_ref_train_pkg.sv */
// Package: constants for the data-input reference level training block
package dq_ref_train_pkg;
	// Field positions of the reference training register
	localparam int ENABLE_BIT     = 7;
	localparam int RANGE_BIT      = 6;
	localparam int LEVEL_MSB      = 5;
	localparam int LEVEL_WIDTH    = 6;
	localparam int REG_WIDTH      = 8;
	// Highest legal level code; codes above are reserved
	localparam logic [5:0] LEVEL_MAX_CODE = 6'h32;
	// Range 1 base 60.00 %, range 2 base 45.00 %, step 0.65 %, in hundredths of a percent
	localparam logic [13:0] RANGE1_BASE_CENTI = 14'h1770;
	localparam logic [13:0] RANGE2_BASE_CENTI = 14'h1194;
	localparam logic [13:0] STEP_CENTI        = 14'h0041;
	// Clock
	localparam int CLK_PERIOD_PS = 4000;
	// Default delays, in ns (no figure given; plain defaults)
	localparam int ENTRY_DELAY_NS      = 150;
	localparam int EXIT_DELAY_NS       = 150;
	localparam int STEP_SHORT_NS       = 80;
	localparam int STEP_LONG_NS        = 250;
	// Cycle counts, least times rounded up
	localparam int ENTRY_DELAY_CYC = (ENTRY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int EXIT_DELAY_CYC  = (EXIT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STEP_SHORT_CYC  = (STEP_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STEP_LONG_CYC   = (STEP_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Level distance above which the long step time applies
	localparam logic [5:0] SHORT_STEP_LIMIT = 6'h04;
	localparam int TIMER_WIDTH = 16;
	typedef enum logic [1:0] {IDLE, ENTERING, TRAINING, EXITING} mode_type;
endpackage

/* core/dq_reference_level_training.sv */
// Data-input reference level training mode: register capture, mode tracking and settle timing
module dq_reference_level_training
#(
	parameter int ENTRY_CYC = dq_ref_train_pkg::ENTRY_DELAY_CYC,
	parameter int EXIT_CYC  = dq_ref_train_pkg::EXIT_DELAY_CYC,
	parameter int SHORT_CYC = dq_ref_train_pkg::STEP_SHORT_CYC,
	parameter int LONG_CYC  = dq_ref_train_pkg::STEP_LONG_CYC
)
(
	// Clock and reset
	input  wire logic                                   clk_i,
	input  wire logic                                   srst_i,
	// Mode register write to the reference training register
	input  wire logic                                   mrs_write_i,
	input  wire logic [dq_ref_train_pkg::REG_WIDTH-1:0] mrs_data_i,
	// Per-device programming mode qualification
	input  wire logic                                   per_device_programming_mode_i,
	input  wire logic                                   lowest_data_bit_i,
	// Reference level state
	output logic                                        training_active_o,
	output logic                                        range_o,
	output logic [dq_ref_train_pkg::LEVEL_WIDTH-1:0]    level_o,
	output logic [13:0]                                 level_centi_pct_o,
	output logic                                        level_programmed_o,
	output logic                                        level_valid_o,
	output logic                                        commands_allowed_o,
	output logic                                        reserved_code_o
);
	import dq_ref_train_pkg::*;

	// Parameters the timers cannot serve are refused at elaboration
	if (ENTRY_CYC < 1)
	begin
		$error("Entry delay must be at least one cycle");
	end
	if (EXIT_CYC < 1)
	begin
		$error("Exit delay must be at least one cycle");
	end
	if (SHORT_CYC < 1)
	begin
		$error("Short step time must be at least one cycle");
	end
	if (LONG_CYC < SHORT_CYC)
	begin
		$error("Long step time must not be below the short one");
	end
	if (ENTRY_CYC >= (1 << TIMER_WIDTH) || EXIT_CYC >= (1 << TIMER_WIDTH) || LONG_CYC >= (1 << TIMER_WIDTH))
	begin
		$error("Timing parameter too large for the timers");
	end

	typedef struct packed {
		mode_type                  mode;
		logic                      active;
		logic                      range;
		logic [LEVEL_WIDTH-1:0]    level;
		logic                      programmed;
		logic                      valid;
		logic [TIMER_WIDTH-1:0]    mode_timer;
		logic [TIMER_WIDTH-1:0]    settle_timer;
		logic [13:0]               centi;
		logic                      reserved;
	} state_type;

	// Level code meaningless until the first update; valid held low
	localparam state_type RESET_STATE = '{
		mode:         IDLE,
		active:       1'h0,
		range:        1'h0,
		level:        '0,
		programmed:   1'h0,
		valid:        1'h0,
		mode_timer:   '0,
		settle_timer: '0,
		centi:        RANGE1_BASE_CENTI,
		reserved:     1'h0
	};

	state_type              state;
	state_type              next_state;

	logic                   executed;
	logic                   write_enable;
	logic                   write_range;
	logic [LEVEL_WIDTH-1:0] write_level;
	logic [LEVEL_WIDTH-1:0] distance;
	logic                   long_step;
	logic                   mode_timer_last;

	// Per-device mode: only a device seeing the lowest data bit low executes
	assign executed     = mrs_write_i && !(per_device_programming_mode_i && lowest_data_bit_i);

	// Fields of the incoming write
	assign write_enable = mrs_data_i[ENABLE_BIT];
	assign write_range  = mrs_data_i[RANGE_BIT];
	assign write_level  = mrs_data_i[LEVEL_MSB:0];
	// Step size picks the settle time; a large jump needs the long one
	assign distance     = (write_level > state.level) ? write_level - state.level
		: state.level - write_level;
	assign long_step    = distance > SHORT_STEP_LIMIT;
	// Entry and exit delays end as the timer reaches zero
	assign mode_timer_last = state.mode_timer <= TIMER_WIDTH'(1);

	always_comb
	begin
		next_state = state;
		// Both timers count down to zero and stop there
		if (state.mode_timer != '0)
		begin
			next_state.mode_timer = state.mode_timer - 1'b1;
		end
		if (state.settle_timer != '0)
		begin
			next_state.settle_timer = state.settle_timer - 1'b1;
		end

		unique case (state.mode)
			IDLE:
			begin
				// Only an enabling write leaves idle; others are discarded
				if (executed && write_enable)
				begin
					// Entry latches the range; its level code is ignored
					next_state.mode = ENTERING;
					next_state.range = write_range;
					next_state.mode_timer = TIMER_WIDTH'(ENTRY_CYC);
				end
			end
			ENTERING:
			begin
				// Writes during the entry delay are not executed
				if (mode_timer_last)
				begin
					next_state.mode = TRAINING;
				end
			end
			TRAINING:
			begin
				if (executed && write_enable)
				begin
					// Range held from entry; only the level changes
					next_state.level = write_level;
					next_state.programmed = 1'h1;
					if (long_step)
					begin
						next_state.settle_timer = TIMER_WIDTH'(LONG_CYC);
					end
					else
					begin
						next_state.settle_timer = TIMER_WIDTH'(SHORT_CYC);
					end
				end
				else if (executed)
				begin
					// Exit keeps the last range and level; bits 6:0 discarded
					next_state.mode = EXITING;
					next_state.mode_timer = TIMER_WIDTH'(EXIT_CYC);
				end
			end
			EXITING:
			begin
				// Writes during the exit delay are not executed
				if (mode_timer_last)
				begin
					next_state.mode = IDLE;
				end
			end
		endcase

		// Flags taken from the next state so outputs need no extra cycle
		next_state.active = next_state.mode == ENTERING || next_state.mode == TRAINING;
		next_state.valid = next_state.programmed && next_state.settle_timer == '0;
		next_state.centi = (next_state.range ? RANGE2_BASE_CENTI : RANGE1_BASE_CENTI)
			+ 14'(next_state.level * STEP_CENTI);
		// Reserved codes are kept and flagged, not refused
		next_state.reserved = next_state.level > LEVEL_MAX_CODE;
	end

	// Synchronous reset of the whole state
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state <= RESET_STATE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Data outputs straight from the state register
	assign training_active_o  = state.active;
	assign range_o            = state.range;
	assign level_o            = state.level;
	assign level_centi_pct_o  = state.centi;
	assign level_programmed_o = state.programmed;
	assign level_valid_o      = state.valid;
	assign reserved_code_o    = state.reserved;
	// Far side may issue commands outside the entry and exit delays
	assign commands_allowed_o = state.mode == TRAINING || state.mode == IDLE;
endmodule

/* dv/dq_ref_train_sva.sv */
// Checker: properties at the reference training block ports
module dq_ref_train_sva
	import dq_ref_train_pkg::*;
(
	input wire logic clk_i, srst_i, mrs_write_i, per_device_programming_mode_i, lowest_data_bit_i,
	input wire logic training_active_o, range_o, level_programmed_o, level_valid_o, commands_allowed_o,
	input wire logic reserved_code_o,
	input wire logic [7:0] mrs_data_i,
	input wire logic [5:0] level_o,
	input wire logic [13:0] level_centi_pct_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	wire acc = mrs_write_i && !(per_device_programming_mode_i && lowest_data_bit_i);
	wire idle = !training_active_o && commands_allowed_o;
	wire trn = training_active_o && commands_allowed_o;
	wire en = mrs_data_i[7];
	a_entry_range: assert property (acc && idle && en |=> training_active_o && !commands_allowed_o
		&& range_o == $past(mrs_data_i[6]) && $stable(level_o)) else $error("entry wrong");
	a_update_level: assert property (acc && trn && en |=> level_o == $past(mrs_data_i[5:0])
		&& $stable(range_o) && level_programmed_o && !level_valid_o) else $error("update wrong");
	a_exit_keeps: assert property (acc && trn && !en |=> !training_active_o && !commands_allowed_o
		&& $stable({range_o, level_o})) else $error("exit wrong");
	a_idle_discard: assert property (mrs_write_i && idle && !en |=> idle && $stable(level_o))
		else $error("idle write taken");
	a_unselected_skip: assert property (mrs_write_i && !acc |=> $stable({training_active_o, level_o}))
		else $error("unselected write taken");
	a_level_map: assert property (level_centi_pct_o == (range_o ? RANGE2_BASE_CENTI : RANGE1_BASE_CENTI)
		+ STEP_CENTI * level_o) else $error("level map wrong");
	a_reserved_flag: assert property (reserved_code_o == (level_o > LEVEL_MAX_CODE)) else $error("flag wrong");
	a_no_default: assert property (!level_programmed_o && !(acc && trn && en) |=> !level_programmed_o
		&& !level_valid_o) else $error("valid too early");
	c_entry: cover property (acc && idle && en);
	c_exit: cover property (acc && trn && !en);
	c_reserved: cover property (reserved_code_o);
endmodule
bind dq_reference_level_training dq_ref_train_sva u_sva (.*);

/* dv/dq_ref_ctrl_model.sv */
// Partner model: controller issuing reference training register writes
module dq_ref_ctrl_model
(
	input  wire logic       clk_i,
	input  wire logic       allowed_i,
	input  wire logic       settled_i,
	output logic            mrs_write_o = 1'b0,
	output logic [7:0]      mrs_data_o = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// Only register writes, no bank activity: banks always idle at exit
	task automatic issue(input logic [7:0] d);
		// A full cycle between calls keeps back-to-back writes apart
		do @(negedge clk_i);
		while (!allowed_i || (!d[7] && !settled_i));
		mrs_write_o = 1'b1;
		mrs_data_o = d;
		@(negedge clk_i);
		mrs_write_o = 1'b0;
		mrs_data_o = ~d;
	endtask
endmodule

/* dv/dq_reference_level_training_test.sv */
// Testbench: reference training block driven by the controller model
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; $display("Error %s exp %0h got %0h", n, e, a); end end
module dq_reference_level_training_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dq_ref_train_pkg::*;
	logic clk_i = 1'b0, srst_i = 1'b1, per_device_programming_mode_i = 1'b0, lowest_data_bit_i = 1'b0;
	logic mrs_write_i, training_active_o, range_o, level_programmed_o, level_valid_o, commands_allowed_o;
	logic reserved_code_o;
	logic [7:0] mrs_data_i;
	logic [5:0] level_o;
	logic [13:0] level_centi_pct_o;
	int num_errors = 0, checks = 0, cycles = 0;
	// Row: write data, per-device, data bit, active, range, level
	logic [17:0] rows [10] = '{{8'h40, 4'h0, 6'h00}, {8'hC5, 4'h3, 6'h00}, {8'h83, 4'h3, 6'h03},
		{8'hF2, 4'h3, 6'h32}, {8'hF3, 4'hF, 6'h32}, {8'hFF, 4'hB, 6'h3F}, {8'hC7, 4'h3, 6'h07},
		{8'h3A, 4'h1, 6'h07}, {8'h80, 4'h2, 6'h07}, {8'h00, 4'h0, 6'h07}};
	dq_ref_ctrl_model ctrl_u (
		.clk_i,
		.allowed_i(commands_allowed_o),
		.settled_i(level_valid_o || !level_programmed_o),
		.mrs_write_o(mrs_write_i),
		.mrs_data_o(mrs_data_i)
	);
	// Exit delay left at its default so the far side waits the full time
	dq_reference_level_training #(.ENTRY_CYC(2), .SHORT_CYC(2), .LONG_CYC(4)) dut_u (.*);
	function automatic logic [13:0] exp_centi(input logic r, input logic [5:0] c);
		return (r ? RANGE2_BASE_CENTI : RANGE1_BASE_CENTI) + STEP_CENTI * c;
	endfunction
	task automatic complete_run();
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial forever #2 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			num_errors++;
			complete_run();
		end
	end
	initial
	begin
		repeat (6) @(negedge clk_i);
		srst_i = 1'b0;
		foreach (rows[i])
		begin
			{per_device_programming_mode_i, lowest_data_bit_i} = rows[i][9:8];
			ctrl_u.issue(rows[i][17:10]);
			`CHK("active", rows[i][7], training_active_o)
			`CHK("range", rows[i][6], range_o)
			`CHK("level", rows[i][5:0], level_o)
			`CHK("centi", exp_centi(rows[i][6], rows[i][5:0]), level_centi_pct_o)
			`CHK("reserved", rows[i][5:0] > LEVEL_MAX_CODE, reserved_code_o)
			repeat (6) @(negedge clk_i);
		end
		srst_i = 1'b1;
		@(negedge clk_i);
		`CHK("programmed", 1'b0, level_programmed_o)
		srst_i = 1'b0;
		ctrl_u.issue(8'hC0);
		`CHK("allowed", 1'b0, commands_allowed_o)
		ctrl_u.issue(8'hC2);
		`CHK("valid", 1'b0, level_valid_o)
		@(negedge clk_i);
		`CHK("valid", 1'b0, level_valid_o)
		@(negedge clk_i);
		`CHK("valid", 1'b1, level_valid_o)
		complete_run();
	end
endmodule
